// >>> hdl/iorp_top.sv
// iorp_top: outbound response path, banks to PCIe DMA, network DMA and test port
// assumes: one clock; the I/O side runs on an enable pulse every IO_DIV cycles,
// the DMA units absorb everything, banks respect their credits
`timescale 1ns/10ps
module iorp_top (
  input  logic         ref_clk,
  input  logic         resetn,
  input  logic [7:0]   bank_vld,
  input  logic [255:0] bank_data,
  output logic [7:0]   bank_credit,
  output logic [3:0]   ib_rd_cnt,
  output logic [3:0]   ib_wr_cnt,
  output logic         dmu_hdr_vld,
  output logic         dmu_datareq,
  output logic [127:0] dmu_data,
  output logic [3:0]   dmu_parity,
  output logic         niu_hdr_vld,
  output logic         niu_datareq,
  output logic [127:0] niu_data,
  output logic [3:0]   niu_parity,
  output logic         tcu_vld,
  output logic         tcu_data
);
  localparam int NB = iorp_pkg::NBANK;
  localparam int ND = iorp_pkg::NDEST;
  localparam int PW = iorp_pkg::DQ_PW;

  logic [NB-1:0]   req;
  logic [NB-1:0]   hdr_seen;
  logic [NB-1:0]   hdr_rd;
  logic [NB-1:0]   pop_w;
  logic [1:0]      hkind [NB];
  logic            hpld  [NB];
  logic [63:0]     lane  [NB];
  logic            gnt_vld;
  logic [2:0]      gnt_idx;
  logic            busy_r;
  logic [2:0]      cur_r;
  logic [2:0]      rr_r;
  logic [3:0]      beat_r;
  logic [3:0]      last_r;
  logic            cur_dest_r;
  logic            ln_vld_r;
  logic            ln_last_r;
  logic            ln_dest_r;
  logic [3:0]      ln_beat_r;
  logic [63:0]     ln_data_r;
  logic [63:0]     pair_r;
  logic [PW-1:0]   wptr_r  [ND];
  logic [PW-1:0]   resv_r  [ND];
  logic [PW-1:0]   wgray_r [ND];
  logic [PW-1:0]   ws1_r   [ND];
  logic [PW-1:0]   ws2_r   [ND];
  logic [PW-1:0]   rgray_r [ND];
  logic [PW-1:0]   rs1_r   [ND];
  logic [PW-1:0]   rs2_r   [ND];
  logic [PW-1:0]   rptr_r  [ND];
  logic [PW-1:0]   wsync_bin [ND];
  logic [ND-1:0]   space_ok;
  logic [ND-1:0]   avail;
  logic [127:0]    hdr_mem [ND][iorp_pkg::DQ_DEPTH];
  logic [127:0]    pld_mem [ND][iorp_pkg::DQ_DEPTH*iorp_pkg::IO_BEATS];
  logic [3:0]      par_mem [ND][iorp_pkg::DQ_DEPTH*iorp_pkg::IO_BEATS];
  logic            io_en_r;
  logic [1:0]      io_cnt_r;
  iorp_pkg::iorp_state_t st_r [ND];
  logic [5:0]      cnt_r [ND];
  logic            hv_r  [ND];
  logic            dr_r  [ND];
  logic [127:0]    dat_r [ND];
  logic [3:0]      par_r [ND];
  logic            tcu_vld_r;
  logic            tcu_data_r;
  logic [63:0]     tcu_sh_r;
  logic [7:0]      credit_r;
  logic [3:0]      ib_rd_r;
  logic [3:0]      ib_wr_r;

  // eight bank buffers with their 8:1 lane mux selected by the arbiter
  for (genvar b = 0; b < NB; b++) begin : g_bank
    iorp_bank_buf u_bank (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .in_vld    (bank_vld[b]),
      .in_word   (bank_data[b*iorp_pkg::BANK_W +: iorp_pkg::BANK_W]),
      .pop       (pop_w[b]),
      .rd_beat   (beat_r),
      .hdr_seen  (hdr_seen[b]),
      .req       (req[b]),
      .head_kind (hkind[b]),
      .head_pld  (hpld[b]),
      .lane_data (lane[b])
    );
    assign hdr_rd[b] = iorp_pkg::needs_pld(
      bank_data[b*iorp_pkg::BANK_W + iorp_pkg::HQ_KIND_LSB +: 2],
      bank_data[b*iorp_pkg::BANK_W]);
    assign pop_w[b] = busy_r && (beat_r == last_r) && (cur_r == 3'(b));
  end

  // space counts reserved slots, so a packet still in flight is already charged
  always_comb begin
    for (int d = 0; d < ND; d++) begin
      space_ok[d]  = PW'(resv_r[d] - iorp_pkg::gray2bin(rs2_r[d])) != PW'(iorp_pkg::DQ_DEPTH);
      wsync_bin[d] = iorp_pkg::gray2bin(ws2_r[d]);
      avail[d]     = rptr_r[d] != wsync_bin[d];
    end
  end

  // round-robin pick among requesters whose destination has room
  always_comb begin
    logic [2:0] cand;
    cand    = 3'h0;
    gnt_vld = 1'b0;
    gnt_idx = 3'h0;
    for (int i = 1; i <= NB; i++) begin
      cand = 3'(rr_r + 3'(i));
      if (!busy_r && !gnt_vld && req[cand] && space_ok[iorp_pkg::dest_of(hkind[cand])]) begin
        gnt_vld = 1'b1;
        gnt_idx = cand;
      end
    end
  end

  // lane transfer: one header beat, then eight 64-bit payload beats when the head carries payload
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r     <= 1'b0;
      cur_r      <= 3'h0;
      rr_r       <= 3'h0;
      beat_r     <= 4'h0;
      last_r     <= 4'h0;
      cur_dest_r <= 1'b0;
    end else if (gnt_vld) begin
      busy_r     <= 1'b1;
      cur_r      <= gnt_idx;
      rr_r       <= gnt_idx;
      beat_r     <= 4'h0;
      last_r     <= hpld[gnt_idx] ? iorp_pkg::LAST_PLD_BEAT : iorp_pkg::LAST_HDR_BEAT;
      cur_dest_r <= iorp_pkg::dest_of(hkind[gnt_idx]);
    end else if (busy_r) begin
      if (beat_r == last_r) busy_r <= 1'b0;
      else beat_r <= beat_r + 4'h1;
    end
  end

  // wire-delay stage after the mux, plus reservation of the queue slot
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ln_vld_r  <= 1'b0;
      ln_last_r <= 1'b0;
      ln_dest_r <= 1'b0;
      ln_beat_r <= 4'h0;
      ln_data_r <= 64'h0;
      for (int d = 0; d < ND; d++) resv_r[d] <= '0;
    end else begin
      ln_vld_r  <= busy_r;
      ln_last_r <= busy_r && (beat_r == last_r);
      ln_dest_r <= cur_dest_r;
      ln_beat_r <= beat_r;
      ln_data_r <= lane[cur_r];
      if (gnt_vld) begin
        resv_r[iorp_pkg::dest_of(hkind[gnt_idx])] <=
          resv_r[iorp_pkg::dest_of(hkind[gnt_idx])] + PW'(1);
      end
    end
  end

  // destination queue fill: header, 128-bit payload pairs and their parity
  always_ff @(posedge ref_clk) begin
    if (ln_vld_r && ln_beat_r == 4'h0) begin
      hdr_mem[ln_dest_r][wptr_r[ln_dest_r][3:0]] <= iorp_pkg::mk_hdr(ln_data_r[17:0]);
    end
    if (ln_vld_r && ln_beat_r[0]) pair_r <= ln_data_r;
    if (ln_vld_r && ln_beat_r != 4'h0 && !ln_beat_r[0]) begin
      pld_mem[ln_dest_r][{wptr_r[ln_dest_r][3:0], 2'(ln_beat_r[3:1] - 3'h1)}] <=
        {pair_r, ln_data_r};
      par_mem[ln_dest_r][{wptr_r[ln_dest_r][3:0], 2'(ln_beat_r[3:1] - 3'h1)}] <=
        iorp_pkg::par4({pair_r, ln_data_r});
    end
  end

  // commit the write pointer only once the whole packet is stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < ND; d++) begin
        wptr_r[d]  <= '0;
        wgray_r[d] <= '0;
      end
    end else if (ln_last_r) begin
      wptr_r[ln_dest_r]  <= wptr_r[ln_dest_r] + PW'(1);
      wgray_r[ln_dest_r] <= iorp_pkg::bin2gray(PW'(wptr_r[ln_dest_r] + PW'(1)));
    end
  end

  // gray pointers through two flops each way; the view is always stale, never early
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < ND; d++) begin
        ws1_r[d] <= '0;
        ws2_r[d] <= '0;
        rs1_r[d] <= '0;
        rs2_r[d] <= '0;
      end
    end else begin
      for (int d = 0; d < ND; d++) begin
        ws1_r[d] <= wgray_r[d];
        ws2_r[d] <= ws1_r[d];
        rs1_r[d] <= rgray_r[d];
        rs2_r[d] <= rs1_r[d];
      end
    end
  end

  // I/O rate enable from the core clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      io_cnt_r <= 2'h0;
      io_en_r  <= 1'b0;
    end else begin
      io_en_r  <= io_cnt_r == 2'(iorp_pkg::IO_DIV - 1);
      io_cnt_r <= (io_cnt_r == 2'(iorp_pkg::IO_DIV - 1)) ? 2'h0 : io_cnt_r + 2'h1;
    end
  end

  // I/O-side sender per destination; outputs move only on the I/O enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < ND; d++) begin
        st_r[d]    <= iorp_pkg::IORP_ST_IDLE;
        cnt_r[d]   <= 6'h0;
        rptr_r[d]  <= '0;
        rgray_r[d] <= '0;
        hv_r[d]    <= 1'b0;
        dr_r[d]    <= 1'b0;
        dat_r[d]   <= 128'h0;
        par_r[d]   <= 4'h0;
      end
      tcu_vld_r  <= 1'b0;
      tcu_data_r <= 1'b0;
      tcu_sh_r   <= 64'h0;
    end else if (io_en_r) begin
      for (int d = 0; d < ND; d++) begin
        case (st_r[d])
          iorp_pkg::IORP_ST_IDLE: begin
            hv_r[d]  <= 1'b0;
            dr_r[d]  <= 1'b0;
            dat_r[d] <= 128'h0;
            par_r[d] <= 4'h0;
            if (avail[d] && hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_KIND_LSB +: 2] ==
                iorp_pkg::IORP_K_TCU) begin
              st_r[d]   <= iorp_pkg::IORP_ST_TCU;
              tcu_vld_r <= 1'b1;
              if (hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_TAG_LSB]) begin
                tcu_data_r <= pld_mem[d][{rptr_r[d][3:0], 2'h0}][127];
                tcu_sh_r   <= {pld_mem[d][{rptr_r[d][3:0], 2'h0}][126:64], 1'b0};
                cnt_r[d]   <= iorp_pkg::TCU_RD_REST;
              end else begin
                tcu_data_r <= 1'b0;
                cnt_r[d]   <= 6'h0;
              end
            end else if (avail[d]) begin
              hv_r[d]  <= 1'b1;
              dat_r[d] <= hdr_mem[d][rptr_r[d][3:0]];
              dr_r[d]  <= iorp_pkg::needs_pld(
                hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_KIND_LSB +: 2],
                hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_TAG_LSB]);
              cnt_r[d] <= 6'h0;
              if (iorp_pkg::needs_pld(hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_KIND_LSB +: 2],
                  hdr_mem[d][rptr_r[d][3:0]][iorp_pkg::PKT_TAG_LSB])) begin
                st_r[d] <= iorp_pkg::IORP_ST_PLD;
              end else begin
                rptr_r[d]  <= rptr_r[d] + PW'(1);
                rgray_r[d] <= iorp_pkg::bin2gray(PW'(rptr_r[d] + PW'(1)));
              end
            end
          end
          iorp_pkg::IORP_ST_PLD: begin
            hv_r[d]  <= 1'b0;
            dr_r[d]  <= 1'b0;
            dat_r[d] <= pld_mem[d][{rptr_r[d][3:0], cnt_r[d][1:0]}];
            par_r[d] <= par_mem[d][{rptr_r[d][3:0], cnt_r[d][1:0]}];
            if (cnt_r[d][1:0] == iorp_pkg::LAST_IO_BEAT) begin
              st_r[d]    <= iorp_pkg::IORP_ST_IDLE;
              rptr_r[d]  <= rptr_r[d] + PW'(1);
              rgray_r[d] <= iorp_pkg::bin2gray(PW'(rptr_r[d] + PW'(1)));
            end else begin
              cnt_r[d] <= cnt_r[d] + 6'h1;
            end
          end
          iorp_pkg::IORP_ST_TCU: begin
            if (cnt_r[d] == 6'h0) begin
              tcu_vld_r  <= 1'b0;
              tcu_data_r <= 1'b0;
              st_r[d]    <= iorp_pkg::IORP_ST_IDLE;
              rptr_r[d]  <= rptr_r[d] + PW'(1);
              rgray_r[d] <= iorp_pkg::bin2gray(PW'(rptr_r[d] + PW'(1)));
            end else begin
              tcu_data_r <= tcu_sh_r[63];
              tcu_sh_r   <= {tcu_sh_r[62:0], 1'b0};
              cnt_r[d]   <= cnt_r[d] - 6'h1;
            end
          end
          default: st_r[d] <= iorp_pkg::IORP_ST_IDLE;
        endcase
      end
    end
  end

  // bank credits on each dequeue, arrival counts by type for the bookkeeper
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      credit_r <= 8'h00;
      ib_rd_r  <= 4'h0;
      ib_wr_r  <= 4'h0;
    end else begin
      credit_r <= pop_w;
      ib_rd_r  <= iorp_pkg::pop8(hdr_seen & hdr_rd);
      ib_wr_r  <= iorp_pkg::pop8(hdr_seen & ~hdr_rd);
    end
  end

  assign bank_credit = credit_r;
  assign ib_rd_cnt   = ib_rd_r;
  assign ib_wr_cnt   = ib_wr_r;
  assign dmu_hdr_vld = hv_r[iorp_pkg::DEST_DMU];
  assign dmu_datareq = dr_r[iorp_pkg::DEST_DMU];
  assign dmu_data    = dat_r[iorp_pkg::DEST_DMU];
  assign dmu_parity  = par_r[iorp_pkg::DEST_DMU];
  assign niu_hdr_vld = hv_r[iorp_pkg::DEST_NIU];
  assign niu_datareq = dr_r[iorp_pkg::DEST_NIU];
  assign niu_data    = dat_r[iorp_pkg::DEST_NIU];
  assign niu_parity  = par_r[iorp_pkg::DEST_NIU];
  assign tcu_vld     = tcu_vld_r;
  assign tcu_data    = tcu_data_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_dmu_pld;
    dmu_hdr_vld |-> dmu_datareq;
  endproperty
  a_dmu_pld: assert property (p_dmu_pld) else $error("pcie header without payload");

  property p_hdr_one;
    (dmu_hdr_vld && io_en_r) |=> !dmu_hdr_vld;
  endproperty
  a_hdr_one: assert property (p_hdr_one) else $error("header valid too long");

  property p_pld_cycles;
    $rose(dmu_hdr_vld) |-> ##2 !dmu_hdr_vld [*8];
  endproperty
  a_pld_cycles: assert property (p_pld_cycles) else $error("header inside payload");

  property p_parity;
    !dmu_hdr_vld |-> dmu_parity == iorp_pkg::par4(dmu_data);
  endproperty
  a_parity: assert property (p_parity) else $error("pcie parity wrong");

  property p_b2b;
    (io_en_r && st_r[1] == iorp_pkg::IORP_ST_IDLE && avail[1]) |=> dmu_hdr_vld;
  endproperty
  a_b2b: assert property (p_b2b) else $error("bubble toward pcie unit");

  property p_gnt_req;
    gnt_vld |-> req[gnt_idx] && space_ok[iorp_pkg::dest_of(hkind[gnt_idx])];
  endproperty
  a_gnt_req: assert property (p_gnt_req) else $error("grant without request or room");

  property p_no_overrun;
    PW'(wsync_bin[0] - rptr_r[0]) <= PW'(iorp_pkg::DQ_DEPTH);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("sender past write pointer");

  property p_wrack;
    (niu_hdr_vld && niu_data[iorp_pkg::PKT_KIND_LSB +: 2] == iorp_pkg::IORP_K_NIU_WR)
      |-> !niu_datareq ##2 (niu_hdr_vld || niu_data == 128'h0);
  endproperty
  a_wrack: assert property (p_wrack) else $error("write ack flagged payload");
endmodule // iorp_top

// >>> hdl/iorp_pkg.sv
// iorp_pkg: constants, types and helpers of the outbound response path
// assumes: single core clock, the I/O rate is an enable pulse derived from it
package iorp_pkg;
  localparam int NBANK       = 8;    // cache banks feeding the path
  localparam int BANK_W      = 32;   // bank response bus
  localparam int LANE_W      = 64;   // internal lane
  localparam int PKT_W       = 128;  // DMA packet bus
  localparam int HQ_W        = 18;   // bank header queue width
  localparam int HQ_DEPTH    = 4;    // bank header queue depth
  localparam int RF_DEPTH    = 32;   // each bank regfile depth
  localparam int PLD_WORDS   = 16;   // 32-bit words per payload
  localparam int IO_BEATS    = 4;    // 128-bit payload beats per packet
  localparam int DQ_DEPTH    = 16;   // destination queue depth
  localparam int DQ_PW       = 5;    // destination pointer width, wrap bit included
  localparam int TCU_BITS    = 64;   // serial read result length
  localparam int IO_DIV      = 2;    // core cycles per I/O cycle
  localparam int NDEST       = 2;
  localparam int DEST_NIU    = 0;    // network DMA queue, also carries test results
  localparam int DEST_DMU    = 1;    // PCIe DMA queue
  localparam int HQ_KIND_LSB = 16;   // kind field in a bank header word
  localparam int PKT_TAG_LSB = 104;  // tag field in the 128-bit header
  localparam int PKT_KIND_LSB = 120; // kind field in the 128-bit header
  localparam logic [3:0] LAST_PLD_BEAT = 4'h8;
  localparam logic [3:0] LAST_HDR_BEAT = 4'h0;
  localparam logic [1:0] LAST_IO_BEAT  = 2'h3;
  localparam logic [5:0] TCU_RD_REST   = 6'h3F;

  typedef enum logic [1:0] {
    IORP_K_NIU_RD = 2'h0,
    IORP_K_NIU_WR = 2'h1,
    IORP_K_DMU_RD = 2'h2,
    IORP_K_TCU    = 2'h3
  } iorp_kind_t;

  // gray along idle -> payload -> idle and idle -> test -> idle
  typedef enum logic [1:0] {
    IORP_ST_IDLE = 2'h0,
    IORP_ST_PLD  = 2'h1,
    IORP_ST_TCU  = 2'h2
  } iorp_state_t;

  // a test response carries its read flag in tag bit 0
  function automatic logic needs_pld(input logic [1:0] kind, input logic tag0);
    return (kind != IORP_K_NIU_WR) && !((kind == IORP_K_TCU) && !tag0);
  endfunction

  function automatic logic dest_of(input logic [1:0] kind);
    return kind == IORP_K_DMU_RD;
  endfunction

  function automatic logic [3:0] par4(input logic [PKT_W-1:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int n = 0; n < 4; n++) p[n] = ^d[32*n +: 32];
    return p;
  endfunction

  function automatic logic [DQ_PW-1:0] bin2gray(input logic [DQ_PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [DQ_PW-1:0] gray2bin(input logic [DQ_PW-1:0] g);
    logic [DQ_PW-1:0] b;
    b = g;
    for (int i = DQ_PW - 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  function automatic logic [3:0] pop8(input logic [NBANK-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < NBANK; i++) c = c + 4'(v[i]);
    return c;
  endfunction

  function automatic logic [PKT_W-1:0] mk_hdr(input logic [HQ_W-1:0] hq);
    logic [PKT_W-1:0] h;
    h = '0;
    h[PKT_KIND_LSB +: 2] = hq[HQ_KIND_LSB +: 2];
    h[PKT_TAG_LSB +: 16] = hq[15:0];
    return h;
  endfunction
endpackage

// >>> hdl/iorp_bank_buf.sv
// iorp_bank_buf: one bank response buffer, header queue plus two regfiles
// assumes: payload words follow their header on consecutive cycles and the
// bank never overruns the four slots (credit returned per pop)
`timescale 1ns/10ps
module iorp_bank_buf (
  input  logic        ref_clk,
  input  logic        resetn,
  input  logic        in_vld,
  input  logic [31:0] in_word,
  input  logic        pop,
  input  logic [3:0]  rd_beat,
  output logic        hdr_seen,
  output logic        req,
  output logic [1:0]  head_kind,
  output logic        head_pld,
  output logic [63:0] lane_data
);
  logic [31:0]             rf_even [iorp_pkg::RF_DEPTH];
  logic [31:0]             rf_odd  [iorp_pkg::RF_DEPTH];
  logic [iorp_pkg::HQ_W-1:0] hq_mem [iorp_pkg::HQ_DEPTH];
  logic [2:0]              hq_wp_r;
  logic [2:0]              hq_rp_r;
  logic                    collect_r;
  logic [3:0]              wcnt_r;
  logic [iorp_pkg::HQ_W-1:0] hold_r;
  logic                    in_pld;
  logic                    push;
  logic [iorp_pkg::HQ_W-1:0] push_hdr;
  logic [iorp_pkg::HQ_W-1:0] head;
  logic [2:0]              ridx;

  // words during a payload are data, never headers
  assign hdr_seen = in_vld && !collect_r;
  assign in_pld   = iorp_pkg::needs_pld(in_word[iorp_pkg::HQ_KIND_LSB +: 2], in_word[0]);
  assign push     = (hdr_seen && !in_pld) || (collect_r && wcnt_r == 4'hF);
  assign push_hdr = collect_r ? hold_r : in_word[iorp_pkg::HQ_W-1:0];
  assign head     = hq_mem[hq_rp_r[1:0]];
  assign req      = hq_wp_r != hq_rp_r;
  assign head_kind = head[iorp_pkg::HQ_KIND_LSB +: 2];
  assign head_pld = iorp_pkg::needs_pld(head_kind, head[0]);
  assign ridx     = 3'(rd_beat - 4'h1);

  // 64-bit read, earlier word in the high half keeps big-endian order
  assign lane_data = (rd_beat == 4'h0) ? {46'h0, head} :
                     {rf_even[{hq_rp_r[1:0], ridx}], rf_odd[{hq_rp_r[1:0], ridx}]};

  // payload capture, 32 bits per cycle; complete packets only reach the queue
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      collect_r <= 1'b0;
      wcnt_r    <= 4'h0;
      hold_r    <= '0;
    end else if (hdr_seen && in_pld) begin
      collect_r <= 1'b1;
      wcnt_r    <= 4'h0;
      hold_r    <= in_word[iorp_pkg::HQ_W-1:0];
    end else if (collect_r) begin
      wcnt_r <= wcnt_r + 4'h1;
      if (wcnt_r == 4'hF) collect_r <= 1'b0;
    end
  end

  // two 32x32 regfiles, slot picked by the header write pointer
  always_ff @(posedge ref_clk) begin
    if (collect_r && wcnt_r[0]) rf_odd[{hq_wp_r[1:0], wcnt_r[3:1]}] <= in_word;
    if (collect_r && !wcnt_r[0]) rf_even[{hq_wp_r[1:0], wcnt_r[3:1]}] <= in_word;
    if (push) hq_mem[hq_wp_r[1:0]] <= push_hdr;
  end

  // header queue pointers; request stays up until the arbiter pops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hq_wp_r <= 3'h0;
      hq_rp_r <= 3'h0;
    end else begin
      if (push) hq_wp_r <= hq_wp_r + 3'h1;
      if (pop) hq_rp_r <= hq_rp_r + 3'h1;
    end
  end
endmodule // iorp_bank_buf

// >>> sim/iorp_dma_sink.sv
// iorp_dma_sink: absorbing model of one DMA unit packet port
// assumes: every beat stands two core cycles; the unit cannot push back
`timescale 1ns/10ps
module iorp_dma_sink (
  input  wire logic         ref_clk,
  input  wire logic         hdr_vld,
  input  wire logic         datareq,
  input  wire logic [127:0] data,
  input  wire logic [3:0]   parity,
  output logic [7:0]        cnt = 8'h00,
  output logic [127:0]      hdr,
  output logic              req,
  output logic [511:0]      pld,
  output logic              ok,
  output logic [7:0]        gap
);
  logic       hv_r = 1'b0;
  logic [7:0] c    = 8'h00;
  // takes every beat as it passes; the count saturates so a stale req never re-arms
  always @(posedge ref_clk) begin
    hv_r <= hdr_vld;
    c    <= (c == 8'hFF) ? c : c + 8'h01;
    if (hdr_vld && !hv_r) begin
      hdr <= data;
      req <= datareq;
      gap <= c + 8'h01;
      ok  <= 1'b1;
      c   <= 8'h00;
      if (!datareq) cnt <= cnt + 8'h01;
    end else if (req && c < 8'h08 && c[0]) begin // mid-beat sample
      pld[128*(3 - c[2:1]) +: 128] <= data;
      ok <= ok & !hdr_vld & (parity === {^data[127:96], ^data[95:64], ^data[63:32],
                                         ^data[31:0]});
      if (c == 8'h07) cnt <= cnt + 8'h01;
    end
  end
endmodule // iorp_dma_sink

// >>> sim/tb_io_outbound_response_path.sv
// tb_io_outbound_response_path: scenario bench for the outbound response path
// assumes: the bench plays the cache banks; two sink models play the DMA units
`timescale 1ns/10ps
module tb_io_outbound_response_path;
  logic         ref_clk = 1'b0, resetn = 1'b0;
  logic [7:0]   bank_vld = 8'h00;
  logic [255:0] bank_data = 256'h0;
  logic [7:0]   bank_credit, cnt [2], gap [2];
  logic [3:0]   ib_rd_cnt, ib_wr_cnt, dmu_parity, niu_parity;
  logic         dmu_hdr_vld, dmu_datareq, niu_hdr_vld, niu_datareq, tcu_vld, tcu_data;
  logic [127:0] dmu_data, niu_data, hdr [2];
  logic [511:0] pld [2];
  logic         req [2], ok [2];
  int           fails = 0, check_count = 0, cyc = 0;
  int           rd_seen = 0, wr_seen = 0, cred_seen = 0;

  iorp_top DUT (.ref_clk, .resetn, .bank_vld, .bank_data, .bank_credit, .ib_rd_cnt,
    .ib_wr_cnt, .dmu_hdr_vld, .dmu_datareq, .dmu_data, .dmu_parity, .niu_hdr_vld,
    .niu_datareq, .niu_data, .niu_parity, .tcu_vld, .tcu_data);
  iorp_dma_sink u_niu (.ref_clk, .hdr_vld(niu_hdr_vld), .datareq(niu_datareq),
    .data(niu_data), .parity(niu_parity), .cnt(cnt[0]), .hdr(hdr[0]), .req(req[0]),
    .pld(pld[0]), .ok(ok[0]), .gap(gap[0]));
  iorp_dma_sink u_dmu (.ref_clk, .hdr_vld(dmu_hdr_vld), .datareq(dmu_datareq),
    .data(dmu_data), .parity(dmu_parity), .cnt(cnt[1]), .hdr(hdr[1]), .req(req[1]),
    .pld(pld[1]), .ok(ok[1]), .gap(gap[1]));

  always #4 ref_clk = ~ref_clk;

  task automatic check(string what, logic [511:0] seen, logic [511:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] wd(int b, int i);
    return 32'hC0DE0000 | 32'(b << 8) | 32'(i);
  endfunction

  // whole line as it should leave, earliest word in the top bits
  function automatic logic [511:0] line(int b);
    logic [511:0] l;
    for (int i = 0; i < 16; i++) l[511-32*i -: 32] = wd(b, i);
    return l;
  endfunction

  // one bank response: header strobe, then n words on consecutive cycles
  task automatic send(int b, logic [1:0] kind, logic [15:0] tag, int n);
    @(posedge ref_clk);
    #1;
    bank_vld[b] = 1'b1;
    bank_data[32*b +: 32] = {14'h0, kind, tag};
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      bank_vld[b] = 1'b0;
      bank_data[32*b +: 32] = wd(b, i);
    end
    @(posedge ref_clk);
    #1;
    bank_vld[b] = 1'b0;
    bank_data[32*b +: 32] = 32'h0;
  endtask

  task automatic wait_pkt(int p, logic [7:0] n0);
    for (int i = 0; i < 300 && cnt[p] == n0; i++) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_dmu;
    logic [7:0] n0;
    n0 = cnt[1];
    fork
      send(3, 2'h2, 16'hBEEF, 16);
      begin
        @(posedge ref_clk);
        send(4, 2'h2, 16'h0A5A, 16);
      end
    join
    wait_pkt(1, n0);
    check("dmu header", hdr[1], {6'h0, 2'h2, 16'hBEEF, 104'h0});
    check("dmu datareq", req[1], 1'b1);
    check("dmu line", pld[1], line(3));
    check("dmu beats", ok[1], 1'b1);
    wait_pkt(1, n0 + 8'h01);
    check("dmu gap", gap[1], 8'h0A);
    check("dmu line 2", pld[1], line(4));
    check("dmu beats 2", ok[1], 1'b1);
  endtask

  task automatic t_niu;
    logic [7:0] n0;
    n0 = cnt[0];
    send(5, 2'h1, 16'h1234, 0);
    check("arrivals", ib_wr_cnt, 4'h1);
    wait_pkt(0, n0);
    check("niu header", hdr[0], {6'h0, 2'h1, 16'h1234, 104'h0});
    check("niu datareq", req[0], 1'b0);
    send(2, 2'h0, 16'h5A5A, 16);
    wait_pkt(0, n0 + 8'h01);
    check("niu read header", hdr[0], {6'h0, 2'h0, 16'h5A5A, 104'h0});
    check("niu read datareq", req[0], 1'b1);
    check("niu line", pld[0], line(2));
    check("niu beats", ok[0], 1'b1);
  endtask

  // every header is reported once by its type, every response returns a credit
  task automatic t_tally;
    check("read arrivals", rd_seen, 4);
    check("write arrivals", wr_seen, 2);
    check("credits", cred_seen, 6);
  endtask

  // serial test result: a read streams the first 64 bits, a write one zero bit
  task automatic t_tcu(logic rd);
    logic [63:0]  s;
    int           n;
    logic [511:0] l;
    l = line(6);
    send(6, 2'h3, {15'h0F0, rd}, rd ? 16 : 0);
    for (int i = 0; i < 300 && tcu_vld !== 1'b1; i++) @(posedge ref_clk);
    #1;
    for (n = 0; n < 128 && tcu_vld === 1'b1; n++) begin
      s = {s[62:0], tcu_data};
      repeat (2) @(posedge ref_clk);
      #1;
    end
    if (rd) check("test read", s, l[511:448]);
    else check("test write", {n, s[0]}, {32'd1, 1'b0});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // pulses stand one cycle, so each edge counts them once; reset keeps them out
  always @(posedge ref_clk) begin
    cyc++;
    if (resetn) begin
      rd_seen   += ib_rd_cnt;
      wr_seen   += ib_wr_cnt;
      cred_seen += $countones(bank_credit);
    end
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    check("reset outputs", {bank_credit, dmu_hdr_vld, niu_hdr_vld, tcu_vld}, 0);
    resetn = 1'b1;
    t_dmu();
    t_niu();
    t_tcu(1'b0);
    t_tcu(1'b1);
    t_tally();
    print_verdict();
  end
endmodule // tb_io_outbound_response_path
